// file: common/tsr_pkg.sv
// task state record engine: offsets, field layout, register map, carriers
// assumes a 32-bit memory port and a 32-bit classic wishbone slave
package tsr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // wishbone register byte offsets
    localparam logic [7:0] TSR_REG_CTRL = 8'h00;
    localparam logic [7:0] TSR_REG_STATUS = 8'h04;
    localparam logic [7:0] TSR_REG_NEW_BASE = 8'h08;
    localparam logic [7:0] TSR_REG_NEW_LIMIT = 8'h0c;
    localparam logic [7:0] TSR_REG_PORT = 8'h10;
    localparam logic [7:0] TSR_REG_GATE = 8'h14;
    localparam logic [7:0] TSR_REG_IDX = 8'h18;
    localparam logic [7:0] TSR_REG_DATA = 8'h1c;
    localparam logic [7:0] TSR_REG_TR_BASE = 8'h20;
    localparam logic [7:0] TSR_REG_TR_LIMIT = 8'h24;

    // control register fields
    localparam int TSR_C_SWITCH = 0;
    localparam int TSR_C_LTR = 1;
    localparam int TSR_C_IO = 2;
    localparam int TSR_C_GATE = 3;
    localparam int TSR_C_CPL = 4;
    localparam int TSR_C_IO_PRIVILEGE_LEVEL = 6;
    localparam int TSR_C_V86 = 8;
    localparam int TSR_C_SIZE = 9;
    localparam int TSR_C_LONG = 11;
    localparam logic [31:0] TSR_CTRL_RST = 32'h0000_0000;

    // status register fields; bits 1..6 are sticky, write one to clear
    localparam int TSR_S_BUSY = 0;
    localparam int TSR_S_DONE = 1;
    localparam int TSR_S_GP = 2;
    localparam int TSR_S_TS = 3;
    localparam int TSR_S_DB = 4;
    localparam int TSR_S_NP = 5;
    localparam int TSR_S_IO_OK = 6;
    localparam int TSR_S_TR_BUSY = 7;
    localparam int TSR_S_GATE_TASK = 8;
    localparam int TSR_S_GATE_DPL = 9;
    localparam int TSR_S_GATE_P = 11;
    localparam logic [6:0] TSR_STICKY_RST = 7'h00;

    // task gate descriptor, upper dword (byte +4)
    localparam int TSR_G_TYPE_LO = 8;
    localparam int TSR_G_S = 12;
    localparam int TSR_G_DPL_LO = 13;
    localparam int TSR_G_P = 15;
    localparam logic [4:0] TSR_GATE_CODE = 5'b00101;

    ////////////////////////////////////////////////////////////////////////
    // record layout, in dword indices of the first 104 bytes
    localparam int TSR_WORDS = 26;
    localparam logic [4:0] TSR_W_LINK = 5'h00;
    localparam logic [4:0] TSR_W_STK_FIRST = 5'h01;
    localparam logic [4:0] TSR_W_STK_LAST = 5'h06;
    localparam logic [4:0] TSR_W_PTB = 5'h07;
    localparam logic [4:0] TSR_W_NIP = 5'h08;
    localparam logic [4:0] TSR_W_FLAGS = 5'h09;
    localparam logic [4:0] TSR_W_GPR_FIRST = 5'h0a;
    localparam logic [4:0] TSR_W_SEG_LAST = 5'h16;
    localparam logic [4:0] TSR_W_LDT = 5'h18;
    localparam logic [4:0] TSR_W_TRAP = 5'h19;
    localparam logic [4:0] TSR_W_IST_FIRST = 5'h09;
    localparam logic [4:0] TSR_W_IST_LAST = 5'h16;
    localparam logic [4:0] TSR_W_LAST = 5'h19;
    localparam int TSR_TRAP_BIT = 0;
    localparam int TSR_IOMAP_LO = 16;
    localparam logic [31:0] TSR_LIMIT_MIN = 32'h0000_0067;
    localparam logic [31:0] TSR_TRAP_OFF = 32'h0000_0064;
    localparam logic [31:0] TSR_DWORD = 32'h0000_0004;

    typedef struct packed {
        logic req;
        logic we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } tsr_mem_req_t;

    // legacy words saved on suspend and read on load
    function automatic logic tsr_is_dynamic(input logic [4:0] idx);
        return idx == TSR_W_LINK ||
            (idx >= TSR_W_NIP && idx <= TSR_W_SEG_LAST);
    endfunction : tsr_is_dynamic

    // words read on load but never written back
    function automatic logic tsr_is_static(input logic [4:0] idx,
                                           input logic long_mode);
        if (long_mode) begin
            return (idx >= TSR_W_STK_FIRST && idx <= TSR_W_STK_LAST) ||
                (idx >= TSR_W_IST_FIRST && idx <= TSR_W_IST_LAST) ||
                idx == TSR_W_TRAP;
        end
        return (idx >= TSR_W_STK_FIRST && idx <= TSR_W_PTB) ||
            idx == TSR_W_LDT || idx == TSR_W_TRAP;
    endfunction : tsr_is_static

endpackage : tsr_pkg

// file: design/tsr_engine.sv
// task state record engine: save/load of records, task register load,
// port permission check and task gate decode
// assumes system memory answers mem_ack_i one or more cycles after a request
//
// Summary of operation
// - static record words are read on load, never written on suspend.
// - dynamic words are read on load and written on suspend.
// - task register load marks busy with no record access or switch.
// - link at 01h-00h dynamic; stack pairs at 1Bh-04h static.
// - page table base at 1Fh-1Ch is static, loaded not saved.
// - instruction pointer 23h-20h and flags 27h-24h are dynamic.
// - general registers 47h-28h and selectors 59h-48h are dynamic.
// - local table selector at 63h-60h is static, read on load.
// - trap bit 0 of byte 64h raises a debug exception on switch.
// - bytes 67h-66h hold the bitmap offset from record base.
// - bitmap checked only in virtual-8086 mode or when cpl exceeds io_privilege_level.
// - one bit per port; all covered bits clear grants, else fault.
// - software places a 0FFh byte after the map; two dwords are fetched.
// - bits beyond the record limit count as set, giving a fault.
// - redirection bitmap has 256 bits, 32 bytes, for v86 interrupts.
// - a switch touches only the first 104 record bytes.
// - 64-bit record: stacks 1Bh-04h, interrupt stacks 5Bh-24h, offset.
// - 64-bit record holds no saved registers, flags or selectors.
// - task gate when bits 12,11:8 of byte +4 are 00101b; dpl 14:13.
// - gate present bit clear gives not-present fault; never modified.
// - switch to a record with limit below 67h faults invalid state.
//
// Chosen here: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
module tsr_engine (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output tsr_pkg::tsr_mem_req_t mem_o,
    input wire logic mem_ack_i,
    input wire logic [31:0] mem_rdata_i
);
    import tsr_pkg::*;

    typedef enum {
        ST_IDLE, ST_SAVE, ST_LOAD, ST_IOBASE, ST_IOMAP0, ST_IOMAP1
    } tsr_state_t;

    tsr_state_t state_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic [31:0] ctrl_q;
    logic [31:0] new_base_q;
    logic [31:0] new_limit_q;
    logic [15:0] port_q;
    logic [31:0] gate_q;
    logic [4:0] sel_idx_q;
    logic [31:0] tr_base_q;
    logic [31:0] tr_limit_q;
    logic tr_busy_q;
    logic [6:0] sticky_q;
    logic [31:0] rec_q [TSR_WORDS];
    logic [4:0] idx_q;
    logic [31:0] map_lo_q;
    logic [16:0] map_byte_q;
    tsr_mem_req_t mem_q;

    logic wr_en;
    logic rd_take;
    logic idle;
    logic go_switch;
    logic go_ltr;
    logic go_io;
    logic go_gate;
    logic [31:0] ctrl_wr;
    logic long_mode;
    logic [1:0] size_code;
    logic need_map;
    logic word_used;
    logic [31:0] word_addr;
    logic [16:0] last_byte;
    logic io_deny;
    logic gate_task;
    logic gate_present;
    logic [6:0] set_flags;

    function automatic logic [31:0] apply_sel(input logic [31:0] old,
                                              input logic [31:0] wdat,
                                              input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = wdat[b*8 +: 8];
            end
        end
        return res;
    endfunction : apply_sel

    ////////////////////////////////////////////////////////////////////////
    // wishbone slave: ack one cycle after request, write at the ack edge
    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
    assign rd_take = wb_cyc_i && wb_stb_i && !ack_q;
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign idle = state_q == ST_IDLE;
    assign ctrl_wr = apply_sel(ctrl_q, wb_dat_i, wb_sel_i);
    assign go_switch = wr_en && wb_adr_i == TSR_REG_CTRL && idle &&
        wb_sel_i[0] && wb_dat_i[TSR_C_SWITCH];
    assign go_ltr = wr_en && wb_adr_i == TSR_REG_CTRL && idle &&
        wb_sel_i[0] && wb_dat_i[TSR_C_LTR];
    assign go_io = wr_en && wb_adr_i == TSR_REG_CTRL && idle &&
        wb_sel_i[0] && wb_dat_i[TSR_C_IO];
    assign go_gate = wr_en && wb_adr_i == TSR_REG_CTRL && idle &&
        wb_sel_i[0] && wb_dat_i[TSR_C_GATE];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= rd_take;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_q <= 32'h0000_0000;
        end else if (rd_take) begin
            case (wb_adr_i)
                TSR_REG_CTRL: rdat_q <= ctrl_q;
                TSR_REG_STATUS: begin
                    rdat_q <= 32'h0000_0000;
                    rdat_q[TSR_S_BUSY] <= !idle;
                    rdat_q[TSR_S_IO_OK:TSR_S_DONE] <= sticky_q[6:1];
                    rdat_q[TSR_S_TR_BUSY] <= tr_busy_q;
                    rdat_q[TSR_S_GATE_TASK] <= gate_task;
                    rdat_q[TSR_S_GATE_DPL +: 2] <= gate_q[TSR_G_DPL_LO +: 2];
                    rdat_q[TSR_S_GATE_P] <= gate_present;
                end
                TSR_REG_NEW_BASE: rdat_q <= new_base_q;
                TSR_REG_NEW_LIMIT: rdat_q <= new_limit_q;
                TSR_REG_PORT: rdat_q <= {16'h0000, port_q};
                TSR_REG_GATE: rdat_q <= gate_q;
                TSR_REG_IDX: rdat_q <= {27'h0000000, sel_idx_q};
                TSR_REG_DATA: rdat_q <= rec_q[sel_idx_q];
                TSR_REG_TR_BASE: rdat_q <= tr_base_q;
                TSR_REG_TR_LIMIT: rdat_q <= tr_limit_q;
                default: rdat_q <= 32'h0000_0000;
            endcase
        end
    end

    // command bits self-clear; mode fields are kept
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= TSR_CTRL_RST;
        end else if (wr_en && wb_adr_i == TSR_REG_CTRL) begin
            ctrl_q <= {ctrl_wr[31:4], 4'h0};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            new_base_q <= 32'h0000_0000;
            new_limit_q <= 32'h0000_0000;
            port_q <= 16'h0000;
            gate_q <= 32'h0000_0000;
            sel_idx_q <= 5'h00;
        end else if (wr_en) begin
            case (wb_adr_i)
                TSR_REG_NEW_BASE:
                    new_base_q <= apply_sel(new_base_q, wb_dat_i, wb_sel_i);
                TSR_REG_NEW_LIMIT:
                    new_limit_q <= apply_sel(new_limit_q, wb_dat_i, wb_sel_i);
                TSR_REG_PORT: port_q <= wb_dat_i[15:0];
                TSR_REG_GATE: gate_q <= apply_sel(gate_q, wb_dat_i, wb_sel_i);
                TSR_REG_IDX: sel_idx_q <= wb_dat_i[4:0];
                default: sel_idx_q <= sel_idx_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decode
    assign long_mode = ctrl_q[TSR_C_LONG];
    assign size_code = ctrl_q[TSR_C_SIZE +: 2];
    // gate decode from software-written descriptor; never written back
    assign gate_task = {gate_q[TSR_G_S], gate_q[TSR_G_TYPE_LO +: 4]} ==
        TSR_GATE_CODE;
    assign gate_present = gate_q[TSR_G_P];
    assign need_map = ctrl_q[TSR_C_V86] ||
        (ctrl_q[TSR_C_CPL +: 2] > ctrl_q[TSR_C_IO_PRIVILEGE_LEVEL +: 2]);
    assign word_used = (state_q == ST_SAVE) ? tsr_is_dynamic(idx_q) :
        (tsr_is_static(idx_q, long_mode) ||
         (!long_mode && tsr_is_dynamic(idx_q)));
    assign word_addr = tr_base_q + {25'h0000000, idx_q, 2'b00};
    // last map byte touched by the access
    // redirection map is the 32 bytes below the offset, not fetched
    assign last_byte = {1'b0, mem_rdata_i[TSR_IOMAP_LO +: 16]} +
        (({1'b0, port_q} + (size_code[1] ? 17'h00003 :
        {16'h0000, size_code[0]})) >> 3);

    tsr_io_perm i_tsr_io_perm (
        .lo_i(map_lo_q),
        .hi_i(mem_rdata_i),
        .byte_off_i(map_byte_q[1:0]),
        .bit_off_i(port_q[2:0]),
        .size_i(size_code),
        .deny_o(io_deny)
    );

    ////////////////////////////////////////////////////////////////////////
    // sequencer and memory port
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            idx_q <= 5'h00;
            mem_q <= '0;
            map_lo_q <= 32'h0000_0000;
            map_byte_q <= 17'h00000;
            set_flags <= 7'h00;
        end else begin
            set_flags <= 7'h00;
            case (state_q)
                ST_IDLE: begin
                    idx_q <= 5'h00;
                    if (go_switch) begin
                        if (new_limit_q < TSR_LIMIT_MIN) begin
                            set_flags[TSR_S_TS] <= 1'b1;
                        end else if (ctrl_wr[TSR_C_LONG]) begin
                            set_flags[TSR_S_GP] <= 1'b1;
                        end else begin
                            state_q <= ST_SAVE;
                        end
                    end else if (go_ltr) begin
                        set_flags[TSR_S_DONE] <= 1'b1;
                    end else if (go_io) begin
                        if (ctrl_wr[TSR_C_V86] ||
                            (ctrl_wr[TSR_C_CPL +: 2] >
                             ctrl_wr[TSR_C_IO_PRIVILEGE_LEVEL +: 2])) begin
                            state_q <= ST_IOBASE;
                            mem_q <= '{1'b1, 1'b0,
                                tr_base_q + TSR_TRAP_OFF, 32'h0000_0000};
                        end else begin
                            set_flags[TSR_S_IO_OK] <= 1'b1;
                            set_flags[TSR_S_DONE] <= 1'b1;
                        end
                    end else if (go_gate) begin
                        if (!gate_present) begin
                            set_flags[TSR_S_NP] <= 1'b1;
                        end else begin
                            set_flags[TSR_S_DONE] <= 1'b1;
                        end
                    end
                end
                ST_SAVE, ST_LOAD: begin
                    if (mem_q.req) begin
                        if (mem_ack_i) begin
                            mem_q.req <= 1'b0;
                            idx_q <= idx_q + 5'h01;
                        end
                    end else if (idx_q > TSR_W_LAST) begin
                        idx_q <= 5'h00;
                        if (state_q == ST_SAVE) begin
                            state_q <= ST_LOAD;
                        end else begin
                            state_q <= ST_IDLE;
                            set_flags[TSR_S_DONE] <= 1'b1;
                        end
                    end else if (word_used) begin
                        mem_q <= '{1'b1, state_q == ST_SAVE, word_addr,
                            rec_q[idx_q]};
                    end else begin
                        idx_q <= idx_q + 5'h01;
                    end
                    if (state_q == ST_LOAD && mem_q.req && mem_ack_i &&
                        idx_q == TSR_W_TRAP && !long_mode &&
                        mem_rdata_i[TSR_TRAP_BIT]) begin
                        set_flags[TSR_S_DB] <= 1'b1;
                    end
                end
                ST_IOBASE: begin
                    if (mem_ack_i) begin
                        map_byte_q <= {1'b0,
                            mem_rdata_i[TSR_IOMAP_LO +: 16]} +
                            {4'h0, port_q[15:3]};
                        if ({15'h0000, last_byte} > tr_limit_q) begin
                            mem_q.req <= 1'b0;
                            state_q <= ST_IDLE;
                            set_flags[TSR_S_GP] <= 1'b1;
                        end else begin
                            state_q <= ST_IOMAP0;
                            mem_q.addr <= tr_base_q + {16'h0000,
                                mem_rdata_i[TSR_IOMAP_LO +: 16] +
                                {3'h0, port_q[15:3]}} & ~32'h3;
                        end
                    end
                end
                ST_IOMAP0: begin
                    if (mem_ack_i) begin
                        map_lo_q <= mem_rdata_i;
                        // second fetch covers an access that spills over
                        mem_q.addr <= mem_q.addr + TSR_DWORD;
                        state_q <= ST_IOMAP1;
                    end
                end
                ST_IOMAP1: begin
                    if (mem_ack_i) begin
                        mem_q.req <= 1'b0;
                        state_q <= ST_IDLE;
                        set_flags[TSR_S_GP] <= io_deny;
                        set_flags[TSR_S_IO_OK] <= !io_deny;
                        set_flags[TSR_S_DONE] <= !io_deny;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
    assign mem_o = mem_q;

    ////////////////////////////////////////////////////////////////////////
    // record image: loaded from memory, software fills dynamic words
    always_ff @(posedge clk_i) begin
        if (state_q == ST_LOAD && mem_q.req && mem_ack_i) begin
            rec_q[idx_q] <= mem_rdata_i;
        end else if (wr_en && wb_adr_i == TSR_REG_DATA && idle) begin
            rec_q[sel_idx_q] <= apply_sel(rec_q[sel_idx_q], wb_dat_i,
                wb_sel_i);
        end
    end

    // task register: descriptor taken on ltr or at switch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tr_base_q <= 32'h0000_0000;
            tr_limit_q <= 32'h0000_0000;
            tr_busy_q <= 1'b0;
        end else if (go_ltr || (state_q == ST_SAVE && !mem_q.req &&
                                idx_q > TSR_W_LAST)) begin
            tr_base_q <= new_base_q;
            tr_limit_q <= new_limit_q;
            tr_busy_q <= 1'b1;
        end
    end

    // sticky flags, set wins over write-one-to-clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sticky_q <= TSR_STICKY_RST;
        end else begin
            sticky_q <= (sticky_q & ~((wr_en && wb_adr_i == TSR_REG_STATUS &&
                wb_sel_i[0]) ? wb_dat_i[6:0] : 7'h00)) | set_flags;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_wait_ack;
        mem_o.req && !mem_ack_i;
    endsequence

    a_req_hold: assert property (s_wait_ack |=> mem_o.req &&
        $stable(mem_o.addr) && $stable(mem_o.we))
        else $error("memory request dropped before ack");
    a_save_dyn_only: assert property ((state_q == ST_SAVE && mem_o.req) |->
        mem_o.we && tsr_is_dynamic(idx_q))
        else $error("non-dynamic word written on suspend");
    a_load_reads: assert property ((state_q == ST_LOAD && mem_o.req) |->
        !mem_o.we)
        else $error("write during record load");
    a_ltr_no_mem: assert property (go_ltr |=> !mem_o.req && tr_busy_q &&
        idle ##1 !mem_o.req)
        else $error("task register load touched memory");
    a_limit_abort: assert property ((go_switch &&
        new_limit_q < TSR_LIMIT_MIN) |=>
        ##1 idle && sticky_q[TSR_S_TS])
        else $error("short record did not abort");
    a_window_104: assert property ((state_q inside {ST_SAVE, ST_LOAD} &&
        mem_o.req) |-> (mem_o.addr - tr_base_q) < 32'd104)
        else $error("switch access past first 104 bytes");
    a_io_bypass: assert property ((go_io && !(ctrl_wr[TSR_C_V86] ||
        ctrl_wr[TSR_C_CPL +: 2] > ctrl_wr[TSR_C_IO_PRIVILEGE_LEVEL +: 2])) |=>
        !mem_o.req ##1 sticky_q[TSR_S_IO_OK])
        else $error("privileged port access consulted bitmap");
    a_trap_debug: assert property ((state_q == ST_LOAD && mem_o.req &&
        mem_ack_i && idx_q == TSR_W_TRAP && !long_mode &&
        mem_rdata_i[TSR_TRAP_BIT]) |=> ##1 sticky_q[TSR_S_DB])
        else $error("trap bit did not raise debug exception");
    a_gate_absent: assert property ((go_gate && !gate_present) |=>
        ##1 sticky_q[TSR_S_NP] && $stable(gate_q))
        else $error("absent gate not faulted");
    a_io_deny: assert property ((state_q == ST_IOMAP1 && mem_ack_i &&
        io_deny) |=> ##1 sticky_q[TSR_S_GP])
        else $error("set permission bit did not fault");
endmodule : tsr_engine

// file: design/tsr_io_perm.sv
// port permission bit evaluation over two fetched bitmap dwords
// assumes the caller fetched the dword holding the first byte and the next
`timescale 1ns/100ps
module tsr_io_perm (
    input wire logic [31:0] lo_i,
    input wire logic [31:0] hi_i,
    input wire logic [1:0] byte_off_i,
    input wire logic [2:0] bit_off_i,
    input wire logic [1:0] size_i,
    output logic deny_o
);
    import tsr_pkg::*;

    logic [63:0] window;
    logic [5:0] shift;
    logic [3:0] mask;
    logic [3:0] bits;

    // byte n/8 of the map, bit n mod 8, lsb first
    assign shift = {1'b0, byte_off_i, bit_off_i};
    assign window = {hi_i, lo_i} >> shift;
    assign bits = window[3:0];
    // one, two or four consecutive bits
    always_comb begin
        case (size_i)
            2'h0: mask = 4'h1;
            2'h1: mask = 4'h3;
            default: mask = 4'hf;
        endcase
    end
    assign deny_o = |(bits & mask);
endmodule : tsr_io_perm

// file: dv/tsr_engine_tb_top.sv
// self-checking bench for the task state record engine
// assumes the memory model and wishbone tasks below drive every input
`timescale 1ns/100ps
module tsr_engine_tb_top;
    import tsr_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, rd, wb_dat_o, mem_rdata;
    logic [3:0] sel = 4'hf;
    logic wb_ack_o, mem_ack;
    tsr_mem_req_t mem_o;
    int err_count = 0, checks_done = 0, hits;
    always #25 clk_i = ~clk_i;
    tsr_engine i_tsr_engine (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .mem_o(mem_o), .mem_ack_i(mem_ack), .mem_rdata_i(mem_rdata));
    tsr_mem_model i_tsr_mem_model (.clk_i(clk_i), .mem_i(mem_o),
        .ack_o(mem_ack), .rdata_o(mem_rdata), .hits_o(hits));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] s, e);
        checks_done++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
        do begin @(posedge clk_i); end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        cyc <= 1'b0; stb <= 1'b0;
    endtask : wb
    // clear sticky flags, start a command, poll until a flag lands
    task automatic run(input logic [31:0] c);
        int n;
        wb(1'b1, TSR_REG_STATUS, 32'h0000_007e);
        wb(1'b1, TSR_REG_CTRL, c);
        n = 0;
        do begin wb(1'b0, TSR_REG_STATUS, 32'h0); n++; end
        while ((rd & 32'h7e) == 32'h0 && n < 200);
        chk("flag landed", {31'h0, |rd[6:1]}, 32'h1);
    endtask : run
    task automatic t_ltr_and_limit();
        int h;
        h = hits;
        wb(1'b1, TSR_REG_NEW_BASE, 32'h0000_0100);
        wb(1'b1, TSR_REG_NEW_LIMIT, 32'h0000_0066);
        run(32'h0000_0001);
        chk("short limit", rd[6:1], 6'h04);
        wb(1'b1, TSR_REG_NEW_LIMIT, 32'h0000_00ff);
        run(32'h0000_0002);
        chk("ltr status", rd[7:1], 7'h41);
        chk("no record access", hits - h, 32'h0);
        wb(1'b0, TSR_REG_TR_BASE, 32'h0);
        chk("tr base", rd, 32'h0000_0100);
        wb(1'b0, 8'hf0, 32'h0);
        chk("unmapped", rd, 32'h0);
    endtask : t_ltr_and_limit
    task automatic t_ports();
        logic [31:0] port [7] = '{0, 2, 3, 7, 3, 7, 32'hffff};
        logic [31:0] ctl [7] = '{32'h4b4, 32'h234, 32'h234, 32'h34, 32'h2f4,
            32'h1f4, 32'h34};
        logic [5:0] exp [7] = '{6'h21, 6'h21, 6'h02, 6'h02, 6'h21, 6'h02,
            6'h02};
        for (int i = 0; i < 7; i++) begin
            wb(1'b1, TSR_REG_PORT, port[i]);
            run(ctl[i]);
            chk("port check", rd[6:1], exp[i]);
        end
    endtask : t_ports
    task automatic t_switch();
        int h;
        wb(1'b1, TSR_REG_IDX, 32'h0000_0008);
        wb(1'b1, TSR_REG_DATA, 32'h1234_5678);
        wb(1'b1, TSR_REG_NEW_BASE, 32'h0000_0200);
        h = hits;
        run(32'h0000_0001);
        wb(1'b0, TSR_REG_DATA, 32'h0);
        chk("loaded word", rd, 32'h0000_8888);
        chk("saved", i_tsr_mem_model.mem_q[8'h48], 32'h1234_5678);
        chk("record accesses", hits - h, 32'h0000_0029);
        wb(1'b0, TSR_REG_STATUS, 32'h0);
        chk("switch status", rd[7:0], 8'h92);
        wb(1'b0, TSR_REG_TR_BASE, 32'h0);
        chk("new tr base", rd, 32'h0000_0200);
        run(32'h0000_0801);
        chk("long switch", rd[6:1], 6'h02);
        run(32'h0000_0802);
        chk("long ltr", rd[6:1], 6'h01);
    endtask : t_switch
    task automatic t_gate();
        wb(1'b1, TSR_REG_GATE, 32'h0000_e500);
        run(32'h0000_0008);
        chk("gate present", rd[11:1], 11'h7c1);
        wb(1'b1, TSR_REG_GATE, 32'h0000_2500);
        run(32'h0000_0008);
        chk("gate absent", {rd[11], rd[5]}, 2'b01);
        wb(1'b0, TSR_REG_GATE, 32'h0);
        chk("gate kept", rd, 32'h0000_2500);
    endtask : t_gate
    task automatic wrap_up();
        if (err_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_ltr_and_limit();
        t_ports();
        t_switch();
        t_gate();
        wrap_up();
    end
    initial begin
        #2000000;
        err_count++;
        wrap_up();
    end
endmodule : tsr_engine_tb_top

// file: dv/tsr_mem_model.sv
// system memory model holding task state records and port bitmaps
// assumes one request at a time on mem_i, answered after three cycles
`timescale 1ns/100ps
module tsr_mem_model (
    input wire logic clk_i,
    input tsr_pkg::tsr_mem_req_t mem_i,
    output logic ack_o,
    output logic [31:0] rdata_o,
    output int hits_o
);
    import tsr_pkg::*;
    logic [31:0] mem_q [256];
    logic [1:0] wait_q;
    initial begin
        ack_o = 1'b0;
        rdata_o = 32'h5a5a_a5a5;
        hits_o = 0;
        wait_q = 2'h0;
        mem_q[8'h59] = 32'h0068_0000;
        mem_q[8'h88] = 32'h0000_8888;
        mem_q[8'h99] = 32'h0000_0001;
        mem_q[8'h5a] = 32'h0000_00f0;
        mem_q[8'h5b] = 32'hffff_ffff;
    end
    // released data toggles so nothing stale passes for an answer
    always @(posedge clk_i) begin
        ack_o <= 1'b0;
        rdata_o <= ~rdata_o;
        if (mem_i.req && !ack_o) begin
            wait_q <= wait_q + 2'h1;
            if (wait_q == 2'h2) begin
                ack_o <= 1'b1;
                wait_q <= 2'h0;
                hits_o <= hits_o + 1;
                if (mem_i.we) begin
                    mem_q[mem_i.addr[9:2]] <= mem_i.wdata;
                end else begin
                    rdata_o <= mem_q[mem_i.addr[9:2]];
                end
            end
        end
    end
endmodule : tsr_mem_model
